//--- blx_core.sv
// Purpose: Executes bit, literal, clear, call and watchdog-kick ops
// Assumes: Software feeds opcodes one at a time through INSTR
// Notes:   One instruction cycle is TCY_CLKS system clocks
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
// Contract
// - Bit clear forces chosen bit of file register low, flags untouched.
// - Bit set forces chosen bit of file register high, flags untouched.
// - AND literal into W, only zero flag updated.
// - Test-skip-if-one discards next instruction when bit is one.
// - Test-skip-if-zero discards next instruction when bit is zero.
// - Zero file register writes 00 and sets zero flag.
// - Zero W loads 00 into W and sets zero flag.
// - Call pushes return address to stack top before PC changes.
// - Call loads 11-bit target into low PC bits.
// - Call fills PC bits 12:11 from page latch bits 4:3.
// - Call takes two instruction cycles and touches no flags.
// - Watchdog kick clears counter and prescaler.
// - Watchdog kick sets timeout and powerdown flags.
// - Read-modify-write on the port register reads the pins.
module blx_core
  import blx_pkg::*;
#(
  parameter int         TCY_CLKS  = TCY_CLKS_DEF,
  parameter logic [6:0] PORT_ADDR = PORT_ADDR_DEF
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Port pins and latch
  input  wire logic [7:0]  port_pins_i,
  output logic      [7:0]  port_latch_o,
  // Stack and watchdog
  output logic             stack_push_o,
  output logic      [12:0] stack_top_o,
  output logic             wdg_timeout_o
);
  localparam int TCW = 8;

  if (TCY_CLKS < 1 || TCY_CLKS > 255) begin : g_chk
    $error("TCY_CLKS must lie in 1..255");
  end

  typedef struct packed {
    logic [TCW-1:0]       tcy;
    blx_phase_t           ph;
    logic                 skip;
    logic [13:0]          ir;
    logic [7:0]           w;
    logic                 z;
    logic                 to;
    logic                 pwd;
    logic [12:0]          pc;
    logic [7:0]           pl;
    logic [12:0]          stk;
    logic                 push;
    logic [6:0]           fa;
    logic [127:0][7:0]    file;
    logic                 ack;
    logic [31:0]          rdata;
  } blx_core_st_t;
  blx_core_st_t st_reg, st_next;

  // ----------------------------------------------------------------
  // Pins and watchdog
  // ----------------------------------------------------------------
  logic [7:0] pins_s;
  blx_wdog_if wd ();

  blx_sync #(.W(8)) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .d_i       (port_pins_i),
    .q_o       (pins_s)
  );

  blx_wdog u_wdog (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .wd        (wd)
  );

  // ----------------------------------------------------------------
  // Decode of the held opcode
  // ----------------------------------------------------------------
  logic [6:0]  ir_f;
  logic [2:0]  ir_b;
  logic [7:0]  bmask;
  logic [7:0]  opnd;
  logic        tick;
  logic        ex;
  logic        op_bclr, op_bset, op_tsz, op_tso;
  logic        op_and, op_call, op_zfile, op_zwreg, op_kick;
  logic        busy;
  logic [7:0]  fsel;

  assign ir_f    = st_reg.ir[6:0];
  assign ir_b    = st_reg.ir[9:7];
  assign bmask   = 8'h01 << ir_b;
  // Port address reads pins, so inputs driven low are seen low
  assign opnd    = (ir_f == PORT_ADDR) ? pins_s
                                       : st_reg.file[ir_f];
  assign op_bclr  = st_reg.ir[13:10] == OPC_BCLR;
  assign op_bset  = st_reg.ir[13:10] == OPC_BSET;
  assign op_tsz   = st_reg.ir[13:10] == OPC_TSZ;
  assign op_tso   = st_reg.ir[13:10] == OPC_TSO;
  assign op_and   = st_reg.ir[13:8]  == OPC_ANDL;
  assign op_call  = st_reg.ir[13:11] == OPC_CALL;
  assign op_zfile = st_reg.ir[13:7]  == OPC_ZFILE;
  assign op_zwreg = st_reg.ir[13:7]  == OPC_ZWREG;
  assign op_kick = st_reg.ir        == OPC_KICK;
  assign tick    = st_reg.tcy == TCW'(TCY_CLKS - 1);
  assign ex      = tick && st_reg.ph == PH_EXEC && !st_reg.skip;
  assign busy    = st_reg.ph != PH_IDLE;
  assign fsel    = (st_reg.fa == PORT_ADDR) ? pins_s
                                            : st_reg.file[st_reg.fa];
  assign wd.tick = tick;
  assign wd.kick = ex && op_kick;

  // ----------------------------------------------------------------
  // Next state: divider, bus slave, executor
  // ----------------------------------------------------------------
  always_comb begin
    st_next      = st_reg;
    st_next.push = 1'b0;
    st_next.tcy  = tick ? '0 : st_reg.tcy + 1'b1;

    // Bus: wait drops one cycle after a request; completes next edge.
    // Writes wait while an opcode is in flight so that bus and
    // executor never update the same register in one edge.
    if (st_reg.ack) begin
      st_next.ack = 1'b0;
      if (avs_write_i) begin
        case (avs_address_i)
          OFS_INSTR: begin
            if (&avs_byteenable_i[1:0]) begin
              st_next.ir = avs_writedata_i[13:0];
              st_next.ph = PH_EXEC;
            end
          end
          OFS_WREG: begin
            if (avs_byteenable_i[0]) st_next.w = avs_writedata_i[7:0];
          end
          OFS_STATUS: begin
            if (avs_byteenable_i[0]) begin
              st_next.z  = avs_writedata_i[ST_Z_BIT];
              st_next.pwd = avs_writedata_i[ST_PWD_BIT];
              st_next.to = avs_writedata_i[ST_TO_BIT];
            end
          end
          OFS_PC: begin
            if (&avs_byteenable_i[1:0]) st_next.pc = avs_writedata_i[12:0];
          end
          OFS_PAGE: begin
            if (avs_byteenable_i[0]) st_next.pl = avs_writedata_i[7:0];
          end
          OFS_FILE_ADDR: begin
            if (avs_byteenable_i[0]) st_next.fa = avs_writedata_i[6:0];
          end
          OFS_FILE_DATA: begin
            if (avs_byteenable_i[0]) begin
              st_next.file[st_reg.fa] = avs_writedata_i[7:0];
            end
          end
          default: begin
          end
        endcase
      end
    end else if (avs_read_i || (avs_write_i && !busy)) begin
      st_next.ack   = 1'b1;
      st_next.rdata = '0;
      if (avs_read_i) begin
        case (avs_address_i)
          OFS_INSTR:     st_next.rdata = {16'h0, busy, st_reg.skip,
                                          st_reg.ir};
          OFS_WREG:      st_next.rdata = {24'h0, st_reg.w};
          OFS_STATUS:    st_next.rdata = {27'h0, st_reg.to, st_reg.pwd,
                                          st_reg.z, 2'b00};
          OFS_PC:        st_next.rdata = {19'h0, st_reg.pc};
          OFS_PAGE:      st_next.rdata = {24'h0, st_reg.pl};
          OFS_STACK_TOP: st_next.rdata = {19'h0, st_reg.stk};
          OFS_WDG:       st_next.rdata = {16'h0, wd.pre, wd.count};
          OFS_FILE_ADDR: st_next.rdata = {25'h0, st_reg.fa};
          OFS_FILE_DATA: st_next.rdata = {24'h0, fsel};
          default:       st_next.rdata = '0;
        endcase
      end
    end

    // Watchdog wrap clears timeout flag; a kick in the same cycle wins
    if (wd.timeout && !wd.kick) st_next.to = 1'b0;

    // Executor, one step per instruction-cycle tick
    if (tick) begin
      case (st_reg.ph)
        PH_EXEC: begin
          st_next.ph = PH_IDLE;
          st_next.pc = st_reg.pc + 13'h0001;
          if (st_reg.skip) begin
            st_next.skip = 1'b0;              // Discarded: runs as NOP
          end else if (op_bclr) begin
            st_next.file[ir_f] = opnd & ~bmask;
          end else if (op_bset) begin
            st_next.file[ir_f] = opnd | bmask;
          end else if (op_tso) begin
            st_next.skip = |(opnd & bmask);
          end else if (op_tsz) begin
            st_next.skip = ~|(opnd & bmask);
          end else if (op_and) begin
            st_next.w = st_reg.w & st_reg.ir[7:0];
            st_next.z = ~|(st_reg.w & st_reg.ir[7:0]);
          end else if (op_zfile) begin
            st_next.file[ir_f] = 8'h00;
            st_next.z          = 1'b1;
          end else if (op_zwreg) begin
            st_next.w = 8'h00;
            st_next.z = 1'b1;
          end else if (op_call) begin
            // Push first, branch in the second cycle
            st_next.stk  = st_reg.pc + 13'h0001;
            st_next.push = 1'b1;
            st_next.pc   = st_reg.pc;
            st_next.ph   = PH_CALL2;
          end else if (op_kick) begin
            st_next.to = 1'b1;
            st_next.pwd = 1'b1;
          end
        end
        PH_CALL2: begin
          st_next.ph = PH_IDLE;
          st_next.pc = {st_reg.pl[PAGE_LO_BIT+1:PAGE_LO_BIT],
                        st_reg.ir[10:0]};
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st_reg    <= '0;
      st_reg.ph <= PH_IDLE;
      st_reg.z  <= RST_Z;
      st_reg.to <= RST_TO;
      st_reg.pwd <= RST_PWD;
      st_reg.pc <= RST_PC;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata_o    = st_reg.rdata;
  assign avs_waitrequest_o = !st_reg.ack;
  assign port_latch_o      = st_reg.file[PORT_ADDR];
  assign stack_push_o      = st_reg.push;
  assign stack_top_o       = st_reg.stk;
  assign wdg_timeout_o     = wd.timeout;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  property p_bclr;
    ex && op_bclr |=> st_reg.file[ir_f][ir_b] == 1'b0 && $stable(st_reg.z);
  endproperty
  a_bclr: assert property (p_bclr) else $error("bit clear failed");

  property p_bset;
    ex && op_bset |=> st_reg.file[ir_f][ir_b] == 1'b1 && $stable(st_reg.z);
  endproperty
  a_bset: assert property (p_bset) else $error("bit set failed");

  // Power-down flag changes only on a watchdog kick or a status write, so it must hold
  property p_and;
    ex && op_and |=> st_reg.w == ($past(st_reg.w) & st_reg.ir[7:0])
      && st_reg.z == (st_reg.w == 8'h00) && $stable(st_reg.pwd);
  endproperty
  a_and: assert property (p_and) else $error("and literal wrong");

  property p_tso;
    ex && op_tso |=> st_reg.skip == |($past(opnd) & $past(bmask));
  endproperty
  a_tso: assert property (p_tso) else $error("skip if one lost");

  property p_tsz;
    ex && op_tsz |=> st_reg.skip == ~|($past(opnd) & $past(bmask));
  endproperty
  a_tsz: assert property (p_tsz) else $error("skip if zero wrong");

  property p_zfile;
    ex && op_zfile |=> st_reg.file[ir_f] == 8'h00 && st_reg.z;
  endproperty
  a_zfile: assert property (p_zfile) else $error("file zero failed");

  property p_zwreg;
    ex && op_zwreg |=> st_reg.w == 8'h00 && st_reg.z;
  endproperty
  a_zwreg: assert property (p_zwreg) else $error("w clear failed");

  property p_push;
    ex && op_call |=> stack_push_o && $stable(st_reg.pc)
      && stack_top_o == $past(st_reg.pc) + 13'h0001;
  endproperty
  a_push: assert property (p_push) else $error("call push wrong");

  property p_target;
    tick && st_reg.ph == PH_CALL2 |=> st_reg.pc ==
      {$past(st_reg.pl[4:3]), st_reg.ir[10:0]};
  endproperty
  a_target: assert property (p_target) else $error("call target");

  property p_twocyc;
    ex && op_call |=> st_reg.ph == PH_CALL2 && $stable(st_reg.z)
      && $stable(st_reg.pwd);
  endproperty
  a_twocyc: assert property (p_twocyc) else $error("call cycles");

  property p_kick;
    ex && op_kick |=> wd.count == '0 && wd.pre == '0
      && st_reg.to && st_reg.pwd;
  endproperty
  a_kick: assert property (p_kick) else $error("kick failed");

  property p_port;
    ex && op_bset && ir_f == PORT_ADDR |=>
      port_latch_o == ($past(pins_s) | $past(bmask));
  endproperty
  a_port: assert property (p_port) else $error("port rmw latch");

endmodule : blx_core

//--- blx_far_model.sv
// Purpose: Far-side stand-in for the executor: stack and port pins
// Assumes: One registered push pulse per call, with stack top valid
// Notes:   Eight-deep stack; the pointer wraps like a real hardware stack
`timescale 1ns/1ps
module blx_far_model (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  // Executor side
  input  wire logic        stack_push_i,
  input  wire logic [12:0] stack_top_i,
  // Bench side
  input  wire logic [7:0]  pin_drive_i,
  output logic      [7:0]  port_pins_o,
  output logic      [12:0] ret_o,
  output logic      [7:0]  push_cnt_o
);
  logic [12:0] stack_mem [8];
  logic [2:0]  sp_reg;

  // The outside device holds the pins at the level the bench asks for
  assign port_pins_o = pin_drive_i;

  // Store the return address on each push; no pop is ever requested
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      sp_reg     <= 3'h0;
      push_cnt_o <= 8'h00;
    end else if (stack_push_i) begin
      stack_mem[sp_reg] <= stack_top_i;
      sp_reg            <= sp_reg + 3'h1;
      push_cnt_o        <= push_cnt_o + 8'h01;
    end
  end

  // Latest pushed entry; unknown until the first push
  assign ret_o = stack_mem[sp_reg - 3'h1];
endmodule : blx_far_model

//--- blx_pkg.sv
// Purpose: Shared constants for the bit/literal/call execution block
// Assumes: 14-bit opcodes, 8-bit data, 13-bit program counter
// Notes:   Byte offsets on a 32-bit Avalon-MM slave, one word each
package blx_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_INSTR     = 8'h00;
  localparam logic [7:0] OFS_WREG      = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_PC        = 8'h0C;
  localparam logic [7:0] OFS_PAGE      = 8'h10;
  localparam logic [7:0] OFS_STACK_TOP = 8'h14;
  localparam logic [7:0] OFS_WDG       = 8'h18;
  localparam logic [7:0] OFS_FILE_ADDR = 8'h1C;
  localparam logic [7:0] OFS_FILE_DATA = 8'h20;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         ST_Z_BIT      = 2;
  localparam int         ST_PWD_BIT    = 3;
  localparam int         ST_TO_BIT     = 4;
  localparam int         IR_SKIP_BIT   = 14;
  localparam int         IR_BUSY_BIT   = 15;
  localparam int         PAGE_LO_BIT   = 3;
  localparam logic       RST_Z         = 1'b0;
  localparam logic       RST_TO        = 1'b1;
  localparam logic       RST_PWD       = 1'b1;
  localparam logic [12:0] RST_PC       = 13'h0000;
  localparam logic [6:0] PORT_ADDR_DEF = 7'h06;

  // ----------------------------------------------------------------
  // Opcode patterns and timing
  // ----------------------------------------------------------------
  localparam logic [3:0] OPC_BCLR      = 4'h4;
  localparam logic [3:0] OPC_BSET      = 4'h5;
  localparam logic [3:0] OPC_TSZ       = 4'h6;
  localparam logic [3:0] OPC_TSO       = 4'h7;
  localparam logic [5:0] OPC_ANDL      = 6'h39;
  localparam logic [2:0] OPC_CALL      = 3'h4;
  localparam logic [6:0] OPC_ZFILE     = 7'h03;
  localparam logic [6:0] OPC_ZWREG     = 7'h02;
  localparam logic [13:0] OPC_KICK     = 14'h0064;
  localparam int         TCY_CLKS_DEF  = 4;
  localparam int         WDG_PRE_W     = 8;
  localparam int         WDG_CNT_W     = 8;

  typedef enum logic [1:0] {PH_IDLE, PH_EXEC, PH_CALL2} blx_phase_t;

endpackage : blx_pkg

//--- blx_sync.sv
// Purpose: Two-flop synchroniser for a pin bus
// Assumes: Bits are independent levels
// Notes:   Only s2 may be read by other logic
`timescale 1ns/1ps
module blx_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rst_b_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } blx_sync_st_t;
  blx_sync_st_t st_reg, st_next;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d_i;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.s2;
endmodule : blx_sync

//--- blx_wdog.sv
// Purpose: Watchdog counter with prescaler on the instruction tick
// Assumes: kick and tick come from the executor
// Notes:   timeout is a one-cycle registered pulse on wrap
`timescale 1ns/1ps
module blx_wdog
  import blx_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  // Executor side
  blx_wdog_if.dog   wd
);
  typedef struct packed {
    logic [WDG_PRE_W-1:0] pre;
    logic [WDG_CNT_W-1:0] cnt;
    logic                 to;
  } blx_wdog_st_t;
  blx_wdog_st_t st_reg, st_next;

  // ----------------------------------------------------------------
  // Counting; a kick restarts both stages at once
  // ----------------------------------------------------------------
  always_comb begin
    st_next    = st_reg;
    st_next.to = 1'b0;
    if (wd.kick) begin
      st_next.pre = '0;
      st_next.cnt = '0;
    end else if (wd.tick) begin
      st_next.pre = st_reg.pre + 1'b1;
      if (&st_reg.pre) begin
        st_next.cnt = st_reg.cnt + 1'b1;
        st_next.to  = &st_reg.cnt;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wd.pre     = st_reg.pre;
  assign wd.count   = st_reg.cnt;
  assign wd.timeout = st_reg.to;
endmodule : blx_wdog

//--- blx_wdog_if.sv
// Purpose: Carrier between the executor and its watchdog
// Assumes: One clock domain
// Notes:   tick is the instruction-cycle enable
`timescale 1ns/1ps
interface blx_wdog_if;
  import blx_pkg::*;
  logic                 tick;
  logic                 kick;
  logic [WDG_PRE_W-1:0] pre;
  logic [WDG_CNT_W-1:0] count;
  logic                 timeout;
  modport core (output tick, output kick,
                input pre, input count, input timeout);
  modport dog  (input tick, input kick,
                output pre, output count, output timeout);
endinterface : blx_wdog_if

//--- tb_top.sv
// Purpose: Self-checking bench for the bit/literal/call executor
// Assumes: Avalon-MM access with waitrequest; TCY_CLKS of 2
// Notes:   Expected values come from opcode semantics, not from the dut
`timescale 1ns/1ps
module tb_top;
  import blx_pkg::*;
  // ----------------------------------------------------------------
  // Signals and case tables
  // ----------------------------------------------------------------
  localparam int         TCY = 2;
  localparam logic [3:0] SK_OP [4] = '{OPC_TSO, OPC_TSO, OPC_TSZ, OPC_TSZ};
  localparam logic [2:0] SK_BIT [4] = '{3'h3, 3'h4, 3'h4, 3'h3};
  localparam logic [3:0] SK_HIT = 4'h5;
  localparam logic [7:0] PG [2] = '{8'h0F, 8'h10};
  localparam logic [10:0] TGT [2] = '{11'h7FF, 11'h001};
  logic        clk_sys;
  logic        rst_b;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  pin_drive;
  logic [7:0]  port_pins;
  logic [7:0]  port_latch;
  logic        stack_push;
  logic [12:0] stack_top;
  logic [12:0] ret;
  logic [7:0]  push_cnt;
  logic [31:0] rd;
  logic [7:0]  exp8;
  logic        wdg_timeout;
  logic        to_seen;
  int          num_errors;
  int          checks;
  // ----------------------------------------------------------------
  // Design and far side
  // ----------------------------------------------------------------
  blx_core #(.TCY_CLKS(TCY), .PORT_ADDR(PORT_ADDR_DEF)) dut_u (
    .clk_sys_i(clk_sys), .rst_b_i(rst_b),
    .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_byteenable_i(avs_byteenable), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest), .port_pins_i(port_pins),
    .port_latch_o(port_latch), .stack_push_o(stack_push),
    .stack_top_o(stack_top), .wdg_timeout_o(wdg_timeout));
  blx_far_model far_u (
    .clk_sys_i(clk_sys), .rst_b_i(rst_b), .stack_push_i(stack_push),
    .stack_top_i(stack_top), .pin_drive_i(pin_drive),
    .port_pins_o(port_pins), .ret_o(ret), .push_cnt_o(push_cnt));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (num_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One access; held until waitrequest is sampled low, bounded wait
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 100) begin
      num_errors++;
      complete_run();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] a,
                       input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk

  // Start an opcode and poll until the busy bit drops
  task automatic exec(input logic [13:0] op);
    int n;
    n = 0;
    wr(OFS_INSTR, {18'h0, op});
    do begin
      bus(1'b0, OFS_INSTR, 32'h0);
      n++;
    end while (rd[IR_BUSY_BIT] !== 1'b0 && n < 50);
    // A core that never goes idle counts as a mismatch
    if (rd[IR_BUSY_BIT] !== 1'b0) num_errors++;
  endtask : exec
  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Sticky record of any wrap; none is due within this short run
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      to_seen <= 1'b0;
    end else if (wdg_timeout === 1'b1) begin
      to_seen <= 1'b1;
    end
  end

  // Tests need about a thousand cycles; this is a generous margin
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    num_errors = 0;
    checks = 0;
    rst_b = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    pin_drive = 8'hA5;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdchk("status reset", OFS_STATUS, 32'h18);
    rdchk("unmapped", 8'h40, 32'h0);
    // Walk every bit position on the top file address, Z held at one
    wr(OFS_FILE_ADDR, 32'h7F);
    wr(OFS_FILE_DATA, 32'hFF);
    wr(OFS_STATUS, 32'h1C);
    exp8 = 8'hFF;
    for (int b = 0; b < 8; b++) begin
      exec({OPC_BCLR, b[2:0], 7'h7F});
      exp8[b] = 1'b0;
      rdchk("file clear", OFS_FILE_DATA, {24'h0, exp8});
    end
    for (int b = 0; b < 8; b++) begin
      exec({OPC_BSET, b[2:0], 7'h7F});
      exp8[b] = 1'b1;
      rdchk("file set", OFS_FILE_DATA, {24'h0, exp8});
    end
    rdchk("status after bit ops", OFS_STATUS, 32'h1C);
    // AND literal: nonzero then zero result
    wr(OFS_WREG, 32'hF0);
    wr(OFS_STATUS, 32'h18);
    exec({OPC_ANDL, 8'h3C});
    rdchk("w and", OFS_WREG, 32'h30);
    rdchk("z clear", OFS_STATUS, 32'h18);
    exec({OPC_ANDL, 8'h0F});
    rdchk("w and zero", OFS_WREG, 32'h0);
    rdchk("z set", OFS_STATUS, 32'h1C);
    // Both skip tests, taken and not taken; follower would clear W
    wr(OFS_FILE_DATA, 32'h08);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_WREG, 32'hFF);
      wr(OFS_PC, 32'h40);
      exec({SK_OP[i], SK_BIT[i], 7'h7F});
      chk("skip pending", 32'(SK_HIT[i]), 32'(rd[IR_SKIP_BIT]));
      exec({OPC_ANDL, 8'h00});
      rdchk("w skip", OFS_WREG, SK_HIT[i] ? 32'hFF : 32'h0);
      rdchk("pc after skip", OFS_PC, 32'h42);
    end
    // Clearing a file register and W both set Z
    wr(OFS_STATUS, 32'h18);
    exec({OPC_ZFILE, 7'h7F});
    rdchk("file zero", OFS_FILE_DATA, 32'h0);
    rdchk("z after file zero", OFS_STATUS, 32'h1C);
    wr(OFS_WREG, 32'h55);
    wr(OFS_STATUS, 32'h18);
    exec({OPC_ZWREG, 7'h00});
    rdchk("w zero", OFS_WREG, 32'h0);
    rdchk("z after w zero", OFS_STATUS, 32'h1C);
    // Calls to the top target 7FF and to target 001, two page selections
    for (int i = 0; i < 2; i++) begin
      wr(OFS_PAGE, {24'h0, PG[i]});
      wr(OFS_PC, 32'h0123);
      wr(OFS_STATUS, 32'h18);
      exec({OPC_CALL, TGT[i]});
      rdchk("stack top", OFS_STACK_TOP, 32'h0124);
      chk("pushed", 32'h0124, {19'h0, ret});
      chk("push count", 32'(i + 1), {24'h0, push_cnt});
      rdchk("pc call", OFS_PC, {19'h0, PG[i][4:3], TGT[i]});
      rdchk("status after call", OFS_STATUS, 32'h18);
    end
    // Kick after the counter has run for hundreds of ticks
    repeat (600) @(posedge clk_sys);
    wr(OFS_STATUS, 32'h0);
    exec(OPC_KICK);
    bus(1'b0, OFS_WDG, 32'h0);
    chk("wdg count", 32'h0, {24'h0, rd[7:0]});
    chk("wdg prescaler", 32'h0, {28'h0, rd[15:12]});
    rdchk("status after kick", OFS_STATUS, 32'h18);
    // Port bit set must start from pin levels, not the empty latch
    wr(OFS_FILE_ADDR, {25'h0, PORT_ADDR_DEF});
    rdchk("pins", OFS_FILE_DATA, 32'hA5);
    exec({OPC_BSET, 3'h1, PORT_ADDR_DEF});
    chk("latch", 32'hA7, {24'h0, port_latch});
    chk("wdg wrap", 32'h0, 32'(to_seen));
    complete_run();
  end
endmodule : tb_top
